// ### f2i_pkg.sv
/*
 * Shared constants and types for the float-to-integer conversion datapath:
 * opcode words, operand field positions, saturation limits and flag reset.
 * Assumes nothing of its surroundings; compiled before every other file.
 */
`default_nettype none

package f2i_pkg;

	// ----------------------------------------------------------------
	// Opcode words
	// ----------------------------------------------------------------
	localparam logic [15:0] LSW_S16   = 16'he68c;
	localparam logic [15:0] LSW_S32   = 16'he688;
	localparam logic [15:0] LSW_U16   = 16'he68e;
	localparam logic [15:0] LSW_U32   = 16'he68a;
	localparam logic [15:0] LSW_FRAC  = 16'he6f1;
	localparam logic [9:0]  MSW_TRUNC = 10'h000;
	localparam logic [9:0]  MSW_ROUND = 10'h200;

	// ----------------------------------------------------------------
	// Field positions in the high opcode word
	// ----------------------------------------------------------------
	localparam int MSW_MODE_LSB = 6;
	localparam int SRC_LSB      = 3;
	localparam int DST_LSB      = 0;
	localparam int REG_SEL_W    = 3;

	// ----------------------------------------------------------------
	// Float format and saturation limits
	// ----------------------------------------------------------------
	localparam logic signed [9:0] EXP_BIAS = 10'sh07f;
	localparam int               FRAC_W   = 23;
	localparam logic [33:0] S16_POS_MAX = 34'h000007fff;
	localparam logic [33:0] S16_NEG_MAX = 34'h000008000;
	localparam logic [33:0] S32_POS_MAX = 34'h07fffffff;
	localparam logic [33:0] S32_NEG_MAX = 34'h080000000;
	localparam logic [33:0] U16_MAX     = 34'h00000ffff;
	localparam logic [33:0] U32_MAX     = 34'h0ffffffff;

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	localparam int         FLAG_W      = 7;
	localparam logic [6:0] FLAGS_RESET = 7'h00;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_S16_ROUND,
		OP_S16_TRUNC,
		OP_S32_TRUNC,
		OP_U16_TRUNC,
		OP_U16_ROUND,
		OP_U32,
		OP_FRAC
	} f2i_op_e;

endpackage

`default_nettype wire

// ### f2i_to_int.sv
/*
 * Combinational float to integer converter with saturation and optional
 * round-half-to-even. Assumes a single-precision input; result is settled
 * within one cycle of the enclosing datapath.
 */
`timescale 1ns/100ps
`default_nettype none

module f2i_to_int
	import f2i_pkg::*;
(
	input  wire logic [31:0] i_float,
	input  wire logic        i_round,
	input  wire logic        i_signed,
	input  wire logic        i_wide,
	output logic      [31:0] o_int
);

	logic              sign;
	logic [7:0]        bexp;
	logic [23:0]       mant;
	logic signed [9:0] shift;
	logic [64:0]       fixed;
	logic [32:0]       int_part;
	logic              inc;
	logic [33:0]       mag;
	logic [33:0]       pos_max;
	logic [33:0]       neg_max;
	logic [33:0]       res;

	always_comb
	begin
		sign  = i_float[31];
		bexp  = i_float[30:23];
		mant  = {(bexp != 8'h00), i_float[22:0]};
		shift = $signed({2'b00, bexp}) - EXP_BIAS;
		// Q33.32 magnitude; denormals count as zero, huge and NaN force saturation
		fixed = {32'h0000_0000, mant, 9'h000};
		if (bexp == 8'h00)
			fixed = '0;
		else if (shift > 10'sh020)
			fixed = {65{1'b1}};
		else if (shift >= 10'sh000)
			fixed = fixed << shift[5:0];
		else if (shift > -10'sh028)
			fixed = fixed >> 6'(-shift);
		else
			fixed = '0;
		int_part = fixed[64:32];
		inc = i_round && fixed[31] && ((|fixed[30:0]) || int_part[0]);
		mag = {1'b0, int_part} + {33'h0, inc};
		pos_max = i_wide ? (i_signed ? S32_POS_MAX : U32_MAX) : (i_signed ? S16_POS_MAX : U16_MAX);
		neg_max = i_signed ? (i_wide ? S32_NEG_MAX : S16_NEG_MAX) : 34'h0;
		if (sign)
			res = (mag > neg_max) ? 34'h0 - neg_max : 34'h0 - mag;
		else
			res = (mag > pos_max) ? pos_max : mag;
		// wide keeps all 32 bits; narrow upper half zero or sign copies
		if (i_wide)
			o_int = res[31:0];
		else if (i_signed)
			o_int = {{16{res[15]}}, res[15:0]};
		else
			o_int = {16'h0000, res[15:0]};
	end

endmodule

`default_nettype wire

// ### f2i_frac.sv
/*
 * Combinational fractional-part extractor for single-precision values.
 * Assumes a single-precision input; NaN and infinity pass through unchanged.
 */
`timescale 1ns/100ps
`default_nettype none

module f2i_frac
	import f2i_pkg::*;
(
	input  wire logic [31:0] i_float,
	output logic      [31:0] o_float
);

	logic [7:0]        bexp;
	logic signed [9:0] shift;
	logic [22:0]       frac;
	logic [4:0]        lead;

	always_comb
	begin
		bexp  = i_float[30:23];
		shift = $signed({2'b00, bexp}) - EXP_BIAS;
		frac  = 23'(i_float[22:0] << shift[4:0]);
		lead  = 5'h00;
		for (int b = 0; b < FRAC_W; b++)
			if (frac[b])
				lead = 5'(b);
		o_float = i_float;
		if (bexp != 8'hff && shift >= 10'sh000)
		begin
			if (shift >= 10'sh017 || frac == 23'h000000)
				o_float = 32'h0000_0000;
			else
				o_float = {i_float[31], 8'(EXP_BIAS - 10'(FRAC_W) + 10'(lead)),
					23'(frac << (5'(FRAC_W) - lead))};
		end
	end

endmodule

`default_nettype wire

// ### f2i_convert.sv
/*
 * Float conversion execution unit: decodes the conversion opcodes, reads
 * the source operand, converts, and hands a write-back to the register
 * file one cycle after issue. Also holds the float status flags, which
 * these operations never touch.
 * Assumes the pipeline presents the source register value in the issue
 * cycle and writes the destination at the clock edge that ends the cycle
 * in which write-back is shown.
 */
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Decode signed 16-bit rounding opcode
// - Round to nearest even, sign extend
// - Decode signed 32-bit truncating opcode
// - Signed 32-bit result, fraction truncated
// - Decode unsigned 16-bit truncating opcode
// - Truncate toward zero, upper half zero
// - Unsigned 16-bit clamps to 65535 first
// - Round variant of unsigned 16-bit
// - Decode unsigned 32-bit opcode
// - Full register unsigned 32-bit result
// - Fraction opcode returns fractional part only
// - No status flag changes from a conversion
// - Result lands after one delay slot
// - Three-bit source and destination selects
// - Signed 16-bit truncating variant, sign extended
module f2i_convert
	import f2i_pkg::*;
(
	input  wire logic                 i_clock,
	input  wire logic                 i_rst,
	input  wire logic                 i_issue,
	input  wire logic [15:0]          i_opcode_lsw,
	input  wire logic [15:0]          i_opcode_msw,
	input  wire logic [31:0]          i_src_data,
	input  wire logic                 i_flag_wr_en,
	input  wire logic [FLAG_W-1:0]    i_flag_wr_data,
	output logic                      o_accept,
	output logic      [REG_SEL_W-1:0] o_src_sel,
	output logic                      o_wb_valid,
	output logic      [REG_SEL_W-1:0] o_wb_dest,
	output logic      [31:0]          o_wb_data,
	output logic                      o_slot_conflict,
	output logic      [FLAG_W-1:0]    o_flags
);

	// ----------------------------------------------------------------
	// Decode
	// ----------------------------------------------------------------
	f2i_op_e              op;
	logic [9:0]           mode;
	logic [REG_SEL_W-1:0] dst_sel;
	logic                 cv_round;
	logic                 cv_signed;
	logic                 cv_wide;
	logic [31:0]          int_res;
	logic [31:0]          frac_res;

	always_comb
	begin
		mode    = i_opcode_msw[15:MSW_MODE_LSB];
		dst_sel = i_opcode_msw[DST_LSB +: REG_SEL_W];
		op      = OP_NONE;
		if (mode == MSW_TRUNC)
		begin
			case (i_opcode_lsw)
				LSW_S16:  op = OP_S16_TRUNC;
				LSW_S32:  op = OP_S32_TRUNC;
				LSW_U16:  op = OP_U16_TRUNC;
				LSW_U32:  op = OP_U32;
				LSW_FRAC: op = OP_FRAC;
				default:  op = OP_NONE;
			endcase
		end
		else if (mode == MSW_ROUND)
		begin
			case (i_opcode_lsw)
				LSW_S16: op = OP_S16_ROUND;
				LSW_U16: op = OP_U16_ROUND;
				default: op = OP_NONE;
			endcase
		end
		cv_round  = (op == OP_S16_ROUND) || (op == OP_U16_ROUND);
		cv_signed = (op == OP_S16_ROUND) || (op == OP_S16_TRUNC) || (op == OP_S32_TRUNC);
		cv_wide   = (op == OP_S32_TRUNC) || (op == OP_U32);
	end

	assign o_accept  = i_issue && (op != OP_NONE);
	assign o_src_sel = i_opcode_msw[SRC_LSB +: REG_SEL_W];

	// ----------------------------------------------------------------
	// Arithmetic
	// ----------------------------------------------------------------
	f2i_to_int u_to_int (
		.i_float  (i_src_data),
		.i_round  (cv_round),
		.i_signed (cv_signed),
		.i_wide   (cv_wide),
		.o_int    (int_res)
	);

	f2i_frac u_frac (
		.i_float (i_src_data),
		.o_float (frac_res)
	);

	// ----------------------------------------------------------------
	// Write-back stage
	// ----------------------------------------------------------------
	logic                 wb_valid;
	logic [REG_SEL_W-1:0] wb_dest;
	logic [31:0]          wb_data;
	logic                 slot_conflict;
	logic                 next_wb_valid;
	logic [REG_SEL_W-1:0] next_wb_dest;
	logic [31:0]          next_wb_data;
	logic                 next_slot_conflict;

	always_comb
	begin
		// one register stage, visible after the slot
		next_wb_valid = o_accept;
		next_wb_dest  = o_accept ? dst_sel : wb_dest;
		next_wb_data  = wb_data;
		if (o_accept)
			next_wb_data = (op == OP_FRAC) ? frac_res : int_res;
		// flag a delay slot touching the pending register
		next_slot_conflict = wb_valid && o_accept && (dst_sel == wb_dest || o_src_sel == wb_dest);
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
		begin
			wb_valid      <= 1'b0;
			wb_dest       <= '0;
			wb_data       <= 32'h0000_0000;
			slot_conflict <= 1'b0;
		end
		else
		begin
			wb_valid      <= next_wb_valid;
			wb_dest       <= next_wb_dest;
			wb_data       <= next_wb_data;
			slot_conflict <= next_slot_conflict;
		end
	end

	assign o_wb_valid      = wb_valid;
	assign o_wb_dest       = wb_dest;
	assign o_wb_data       = wb_data;
	assign o_slot_conflict = slot_conflict;

	// ----------------------------------------------------------------
	// Status flags
	// ----------------------------------------------------------------
	logic [FLAG_W-1:0] flags;
	logic [FLAG_W-1:0] next_flags;

	// Conversions have no path into the flags; only other units write them
	always_comb
	begin
		next_flags = i_flag_wr_en ? i_flag_wr_data : flags;
	end

	always_ff @(posedge i_clock)
	begin
		if (i_rst)
			flags <= FLAGS_RESET;
		else
			flags <= next_flags;
	end

	assign o_flags = flags;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	s16r_decode_a:
	assert property (i_issue && i_opcode_lsw == 16'he68c && i_opcode_msw[15:6] == 10'h200
		|-> op == OP_S16_ROUND ##1 o_wb_valid)
		else $error("signed 16-bit round opcode not taken");

	s16r_even_a:
	assert property (o_accept && op == OP_S16_ROUND && i_src_data == 32'h40200000
		|=> o_wb_data == 32'h00000002)
		else $error("2.5 did not round to 2");

	s16r_up_a:
	assert property (o_accept && op == OP_S16_ROUND && i_src_data == 32'h40600000
		|=> o_wb_data == 32'h00000004)
		else $error("3.5 did not round to 4");

	s32_decode_a:
	assert property (i_issue && i_opcode_lsw == 16'he688 && i_opcode_msw[15:6] == 10'h000
		|=> o_wb_valid && o_wb_dest == $past(i_opcode_msw[2:0]))
		else $error("signed 32-bit opcode not written back");

	s32_value_a:
	assert property (o_accept && op == OP_S32_TRUNC && i_src_data == 32'hcb2af5a5
		|=> o_wb_data == 32'hff550a5b)
		else $error("signed 32-bit truncation wrong");

	u16_decode_a:
	assert property (i_issue && i_opcode_lsw == 16'he68e && i_opcode_msw[15:6] == 10'h000
		|-> op == OP_U16_TRUNC ##1 o_wb_valid)
		else $error("unsigned 16-bit opcode not taken");

	u16_upper_a:
	assert property (o_accept && (op == OP_U16_TRUNC || op == OP_U16_ROUND)
		|=> o_wb_data[31:16] == 16'h0000)
		else $error("unsigned 16-bit upper half not zero");

	u16_neg_a:
	assert property (o_accept && op == OP_U16_TRUNC && i_src_data == 32'hc1100000
		|=> o_wb_data == 32'h00000000)
		else $error("negative unsigned 16-bit not zero");

	u16_sat_a:
	assert property (o_accept && op == OP_U16_TRUNC && i_src_data == 32'h48927c00
		|=> o_wb_data == 32'h0000ffff)
		else $error("unsigned 16-bit did not saturate");

	u16r_value_a:
	assert property (o_accept && op == OP_U16_ROUND && i_src_data == 32'h412ccccd
		|=> o_wb_data == 32'h0000000b)
		else $error("unsigned 16-bit round wrong");

	u32_decode_a:
	assert property (i_issue && i_opcode_lsw == 16'he68a && i_opcode_msw[15:6] == 10'h000
		|-> op == OP_U32 ##1 o_wb_valid)
		else $error("unsigned 32-bit opcode not taken");

	u32_value_a:
	assert property (o_accept && op == OP_U32 && i_src_data == 32'h41480000
		|=> o_wb_data == 32'h0000000c)
		else $error("unsigned 32-bit result wrong");

	frac_value_a:
	assert property (o_accept && op == OP_FRAC && i_src_data == 32'h419d0000
		|=> o_wb_data == 32'h3f200000)
		else $error("fraction part wrong");

	flags_hold_a:
	assert property (!i_flag_wr_en |=> $stable(o_flags))
		else $error("status flags changed without a write");

	wb_timing_a:
	assert property ((o_accept |=> o_wb_valid) and (!o_accept |=> !o_wb_valid))
		else $error("write-back not one cycle after issue");

	conflict_a:
	assert property (o_accept ##1 (o_accept && o_src_sel == $past(dst_sel)) |=> o_slot_conflict)
		else $error("delay slot conflict not flagged");

	dest_sel_a:
	assert property (o_accept |=> o_wb_dest == $past(i_opcode_msw[2:0]))
		else $error("destination select wrong");

	s16t_value_a:
	assert property (o_accept && op == OP_S16_TRUNC && i_src_data == 32'hc0a00000
		|=> o_wb_data == 32'hfffffffb)
		else $error("signed 16-bit truncation wrong");

	s16_signext_a:
	assert property (o_accept && (op == OP_S16_TRUNC || op == OP_S16_ROUND)
		|=> o_wb_data[31:16] == {16{o_wb_data[15]}})
		else $error("signed 16-bit not sign extended");

	s16_clamp_a:
	assert property (o_accept && op == OP_S16_TRUNC && i_src_data == 32'hc7c35000
		|=> o_wb_data == 32'hffff8000)
		else $error("signed 16-bit did not saturate low");

	no_decode_a:
	assert property (i_issue && op == OP_NONE |=> !o_wb_valid)
		else $error("unknown opcode written back");

	round_cov: cover property (o_accept && op == OP_S16_ROUND ##1 o_wb_valid);
	b2b_cov: cover property (o_accept ##1 o_accept ##1 o_wb_valid);
	frac_cov: cover property (o_accept && op == OP_FRAC);
	conflict_cov: cover property (o_slot_conflict);

endmodule

`default_nettype wire

// ### f2i_host_model.sv
/*
 * Host side model: eight float registers read through the source select
 * and written on the write-back strobe.
 * Assumes one clock shared with the datapath.
 */
`timescale 1ns/100ps
`default_nettype none

module f2i_host_model
(
	input  wire logic        i_clock,
	input  wire logic [2:0]  i_src_sel,
	input  wire logic        i_wb_valid,
	input  wire logic [2:0]  i_wb_dest,
	input  wire logic [31:0] i_wb_data,
	output logic      [31:0] o_src_data
);
	// Plain always so the bench may preload operands between edges
	logic [31:0] regs [8];

	assign o_src_data = regs[i_src_sel];

	// write lands at the end of the slot
	always @(posedge i_clock)
	begin
		if (i_wb_valid)
		begin
			regs[i_wb_dest] <= i_wb_data;
		end
	end
endmodule

`default_nettype wire

// ### float_to_int_convert_test.sv
/*
 * Self-checking bench for the conversion unit: directed and seeded random
 * instruction streams, refusals, slot conflicts and flag writes.
 * Assumes the host model supplies operands and takes write-backs.
 */
`timescale 1ns/100ps
`default_nettype none

module float_to_int_convert_test
	import f2i_pkg::*;
;
	localparam logic [15:0] OP_LSW [6] = '{LSW_S16, LSW_S16, LSW_S32, LSW_U16, LSW_U16, LSW_U32};
	localparam logic [9:0]  OP_MODE [6] = '{MSW_ROUND, MSW_TRUNC, MSW_TRUNC, MSW_TRUNC, MSW_ROUND, MSW_TRUNC};
	localparam logic [31:0] FLIST [15] = '{32'h40200000, 32'h40600000, 32'hc0200000, 32'h47886800,
		32'h471c4000, 32'hcf800000, 32'h41480000, 32'h412ccccd, 32'hc1100000, 32'h4b2af5a5,
		32'hcb2af5a5, 32'h477fff80, 32'h3f000000, 32'h7f800000, 32'hff800000};
	localparam logic [31:0] FR_IN [4] = '{32'h419d0000, 32'h3e800000, 32'h41000000, 32'hc0200000};
	localparam logic [31:0] FR_OUT [4] = '{32'h3f200000, 32'h3e800000, 32'h00000000, 32'hbf000000};

	logic        i_clock = 1'b0;
	logic        i_rst = 1'b1;
	logic        i_issue = 1'b0;
	logic [15:0] i_opcode_lsw = 16'h0;
	logic [15:0] i_opcode_msw = 16'h0;
	logic [31:0] i_src_data;
	logic        i_flag_wr_en = 1'b0;
	logic [6:0]  i_flag_wr_data = 7'h0;
	logic        o_accept;
	logic [2:0]  o_src_sel;
	logic        o_wb_valid;
	logic [2:0]  o_wb_dest;
	logic [31:0] o_wb_data;
	logic        o_slot_conflict;
	logic [6:0]  o_flags;
	logic        pend_v = 1'b0;
	logic        pend_conf = 1'b0;
	logic [2:0]  pend_dst = 3'h0;
	logic [31:0] pend_data;
	logic [6:0]  flag_exp = 7'h0;
	logic [31:0] r;
	logic [31:0] fv;
	int          n_errors = 0;
	int          checks_done = 0;
	int          cycles = 0;
	integer      seed = 32'hea8523c8;

	always #12.5 i_clock = ~i_clock;

	f2i_convert f2i_convert_i (.i_clock(i_clock), .i_rst(i_rst), .i_issue(i_issue),
		.i_opcode_lsw(i_opcode_lsw), .i_opcode_msw(i_opcode_msw), .i_src_data(i_src_data),
		.i_flag_wr_en(i_flag_wr_en), .i_flag_wr_data(i_flag_wr_data), .o_accept(o_accept),
		.o_src_sel(o_src_sel), .o_wb_valid(o_wb_valid), .o_wb_dest(o_wb_dest), .o_wb_data(o_wb_data),
		.o_slot_conflict(o_slot_conflict), .o_flags(o_flags));

	f2i_host_model f2i_host_model_i (.i_clock(i_clock), .i_src_sel(o_src_sel), .i_wb_valid(o_wb_valid),
		.i_wb_dest(o_wb_dest), .i_wb_data(o_wb_data), .o_src_data(i_src_data));

	// ----------------------------------------
	// Expectations and checks
	// ----------------------------------------
	// Magnitude first, half-to-even, then clamp, so saturation never wraps
	function automatic logic [31:0] conv_exp(input logic [31:0] f, input int op);
		longint unsigned mag;
		longint unsigned rem;
		longint unsigned lim;
		int              sh;
		logic            wide;
		sh = int'(f[30:23]) - 150;
		wide = (op == 2) || (op == 5);
		mag = 0;
		if (f[30:23] == 8'hff || sh > 20)
			mag = 64'h100000000000;
		else if (f[30:23] != 8'h00 && sh >= 0)
			mag = {40'h0, 1'b1, f[22:0]} << sh;
		else if (f[30:23] != 8'h00 && sh >= -25)
		begin
			mag = {40'h0, 1'b1, f[22:0]} >> -sh;
			rem = {40'h0, 1'b1, f[22:0]} & ((64'h1 << -sh) - 1);
			lim = 64'h1 << (-sh - 1);
			if (OP_MODE[op] == MSW_ROUND && (rem > lim || (rem == lim && mag[0])))
				mag = mag + 1;
		end
		if (op < 3)
		begin
			lim = (wide ? 64'h7fffffff : 64'h7fff) + {63'h0, f[31]};
			if (mag > lim)
				mag = lim;
			if (f[31])
				mag = -mag;
			return wide ? mag[31:0] : {{16{mag[15]}}, mag[15:0]};
		end
		lim = wide ? 64'hffffffff : 64'hffff;
		if (f[31])
			mag = 0;
		else if (mag > lim)
			mag = lim;
		return mag[31:0];
	endfunction

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Checks last cycle's issue, then presents one instruction
	task automatic step(input logic iss, input logic [15:0] lsw, input logic [9:0] mode,
		input logic [2:0] dst, input logic [2:0] src, input logic [31:0] f, input logic [31:0] ev,
		input logic acc);
		@(negedge i_clock);
		check("wb_valid", {31'h0, o_wb_valid}, {31'h0, pend_v});
		if (pend_v)
		begin
			check("wb_dest", {29'h0, o_wb_dest}, {29'h0, pend_dst});
			check("wb_data", o_wb_data, pend_data);
		end
		check("slot_conflict", {31'h0, o_slot_conflict}, {31'h0, pend_conf});
		check("flags", {25'h0, o_flags}, {25'h0, flag_exp});
		i_flag_wr_en = ($random(seed) & 7) == 0;
		i_flag_wr_data = 7'($random(seed));
		if (i_flag_wr_en)
			flag_exp = i_flag_wr_data;
		f2i_host_model_i.regs[src] = f;
		i_issue = iss;
		i_opcode_lsw = lsw;
		i_opcode_msw = {mode, src, dst};
		#1;
		check("accept", {31'h0, o_accept}, {31'h0, iss & acc});
		check("src_sel", {29'h0, o_src_sel}, {29'h0, src});
		pend_conf = pend_v && iss && acc && (dst == pend_dst || src == pend_dst);
		pend_v = iss & acc;
		pend_dst = dst;
		pend_data = ev;
	endtask

	task automatic test_done();
		$display("checks %0d mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	always @(posedge i_clock)
	begin
		cycles++;
		if (cycles > 100000)
		begin
			n_errors++;
			test_done();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		repeat (12) @(posedge i_clock);
		@(negedge i_clock);
		i_rst = 1'b0;
		check("reset_data", o_wb_data, 32'h0);
		for (int k = 0; k < 90; k++)
			step(1'b1, OP_LSW[k % 6], OP_MODE[k % 6], 3'(k), 3'(k + 3), FLIST[k / 6], conv_exp(FLIST[k / 6], k % 6), 1'b1);
		for (int k = 0; k < 4; k++)
			step(1'b1, LSW_FRAC, MSW_TRUNC, 3'(k), 3'(k + 4), FR_IN[k], FR_OUT[k], 1'b1);
		$display("test directed done");
		// Refused opcode, then delay-slot source and destination conflicts
		step(1'b1, LSW_S32, MSW_ROUND, 3'h1, 3'h2, 32'h40200000, 32'h0, 1'b0);
		step(1'b1, LSW_U32, MSW_TRUNC, 3'h3, 3'h1, 32'h41480000, 32'hc, 1'b1);
		step(1'b1, LSW_U32, MSW_TRUNC, 3'h5, 3'h3, 32'h41000000, 32'h8, 1'b1);
		step(1'b1, LSW_U32, MSW_TRUNC, 3'h5, 3'h0, 32'h40400000, 32'h3, 1'b1);
		step(1'b0, LSW_U32, MSW_TRUNC, 3'h2, 3'h4, 32'h0, 32'h0, 1'b1);
		$display("test refusal and conflict done");
		for (int k = 0; k < 400; k++)
		begin
			r = $random(seed);
			fv = $random(seed);
			fv[30:23] = 8'd100 + 8'(fv[28:23]);
			// random stream keeps the slot clear of the pending register
			step(r[31] | r[30], OP_LSW[r[7:0] % 6], OP_MODE[r[7:0] % 6], pend_dst + 3'(1 + r[10:8] % 7),
				pend_dst + 3'(1 + r[14:12] % 7), fv, conv_exp(fv, r[7:0] % 6), 1'b1);
		end
		step(1'b0, LSW_S16, MSW_TRUNC, 3'h0, 3'h1, 32'h0, 32'h0, 1'b1);
		step(1'b0, LSW_S16, MSW_TRUNC, 3'h0, 3'h1, 32'h0, 32'h0, 1'b1);
		$display("test random done");
		test_done();
	end
endmodule

`default_nettype wire
